// ---- logical_shift_unit_bench.sv ----
// Self-checking testbench for the logical shift unit.
`timescale 1ns/10ps
`default_nettype none
module logical_shift_unit_bench;
   import lsu_pkg::*;
   logic ref_clk_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic exec_i = 1'h0;
   lsu_op_type op_i = shift_left_logical_op;
   logic dest_i = 1'h0;
   logic [6:0] addr_i = 7'h00;
   logic [7:0] operand_i = 8'h00;
   logic [7:0] result_o, acc, file;
   logic acc_we_o, file_we_o, flags_we_o, carry_o, zero_o;
   logic [6:0] file_addr_o, maddr;
   logic [1:0] flags;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   // Row: op, dest, operand, result, carry, zero.
   logic [19:0] rows [6] = '{{2'h0, 8'h81, 8'h02, 2'h2}, {2'h1, 8'h80, 8'h00, 2'h3},
      {2'h0, 8'h7F, 8'hFE, 2'h0}, {2'h3, 8'h01, 8'h00, 2'h3},
      {2'h2, 8'hFE, 8'h7F, 2'h0}, {2'h3, 8'h80, 8'h40, 2'h0}};
   lsu_logical_shift_unit dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .exec_i(exec_i),
      .op_i(op_i), .dest_i(dest_i), .addr_i(addr_i), .operand_i(operand_i),
      .result_o(result_o), .acc_we_o(acc_we_o), .file_we_o(file_we_o),
      .file_addr_o(file_addr_o), .flags_we_o(flags_we_o), .carry_o(carry_o),
      .zero_o(zero_o));
   lsu_core_model core_u (.ref_clk_i(ref_clk_i), .result_i(result_o), .acc_we_i(acc_we_o),
      .file_we_i(file_we_o), .file_addr_i(file_addr_o), .flags_we_i(flags_we_o),
      .carry_i(carry_o), .zero_i(zero_o), .acc_o(acc), .file_o(file), .addr_o(maddr),
      .flags_o(flags));
   initial forever #10 ref_clk_i = ~ref_clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [31:0] outs();
      return {result_o, carry_o, zero_o, acc_we_o, file_we_o, flags_we_o, file_addr_o};
   endfunction
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 400) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      repeat (9) @(posedge ref_clk_i);
      #1 check(outs(), 32'h0000_0000);
      @(posedge ref_clk_i);
      #1 rst_n_i = 1'h1;
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk_i);
         #1 exec_i = 1'h1;
         op_i = lsu_op_type'(rows[i][19]);
         dest_i = rows[i][18];
         operand_i = rows[i][17:10];
         addr_i = 7'(i * 25);
         @(posedge ref_clk_i);
         #1 exec_i = 1'h0;
         check(outs(), {rows[i][9:0], ~dest_i, dest_i, 1'h1, addr_i});
         @(posedge ref_clk_i);
         #1 check({dest_i ? file : acc, flags}, rows[i][9:0]);
         if (dest_i) check(maddr, addr_i);
      end
      $display("table test done");
      @(posedge ref_clk_i);
      #1 exec_i = 1'h1;
      op_i = shift_left_logical_op;
      dest_i = 1'h1;
      operand_i = 8'hC0;
      addr_i = 7'h7F;
      @(posedge ref_clk_i);
      #1 op_i = shift_right_logical_op;
      dest_i = 1'h0;
      operand_i = 8'h03;
      check(outs(), {8'h80, 5'h13, 7'h7F});
      @(posedge ref_clk_i);
      #1 exec_i = 1'h0;
      check(outs(), {8'h01, 5'h15, 7'h7F});
      @(posedge ref_clk_i);
      #1 check(outs(), {8'h01, 5'h10, 7'h7F});
      rst_n_i = 1'h0;
      @(posedge ref_clk_i);
      #1 check(outs(), 32'h0000_0000);
      rst_n_i = 1'h1;
      exec_i = 1'h1;
      op_i = shift_right_logical_op;
      dest_i = 1'h1;
      operand_i = 8'h02;
      addr_i = 7'h05;
      @(posedge ref_clk_i);
      #1 exec_i = 1'h0;
      check(outs(), {8'h01, 5'h03, 7'h05});
      $display("back to back and reset test done");
      close_out();
   end
endmodule // logical_shift_unit_bench
`default_nettype wire

// ---- lsu_core_model.sv ----
// Model of the core register file and status flags fed by the shift unit.
`timescale 1ns/10ps
`default_nettype none
module lsu_core_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] result_i,
   input wire logic acc_we_i,
   input wire logic file_we_i,
   input wire logic [6:0] file_addr_i,
   input wire logic flags_we_i,
   input wire logic carry_i,
   input wire logic zero_i,
   output logic [7:0] acc_o,
   output logic [7:0] file_o,
   output logic [6:0] addr_o,
   output logic [1:0] flags_o
);
   always @(posedge ref_clk_i) begin
      if (acc_we_i) acc_o <= result_i;
      if (file_we_i) begin
         file_o <= result_i;
         addr_o <= file_addr_i;
      end
      if (flags_we_i) flags_o <= {carry_i, zero_i};
   end
endmodule // lsu_core_model
`default_nettype wire

// ---- lsu_logical_shift_unit.sv ----
// Logical shift datapath slice between the register file and the status flags.
`timescale 1ns/10ps
`default_nettype none
module lsu_logical_shift_unit
   import lsu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic exec_i,
   input wire lsu_pkg::lsu_op_type op_i,
   input wire logic dest_i,
   input wire logic [lsu_pkg::ADDR_W-1:0] addr_i,
   input wire logic [lsu_pkg::DATA_W-1:0] operand_i,
   output logic [lsu_pkg::DATA_W-1:0] result_o,
   output logic acc_we_o,
   output logic file_we_o,
   output logic [lsu_pkg::ADDR_W-1:0] file_addr_o,
   output logic flags_we_o,
   output logic carry_o,
   output logic zero_o
);
   import lsu_pkg::*;

   // One instruction takes one cycle; outputs are registered and valid the cycle after exec_i.
   logic [7:0] shift_res;
   logic shift_c;
   logic shift_z;
   logic [7:0] result_d, result_q;
   logic acc_we_d, acc_we_q;
   logic file_we_d, file_we_q;
   logic [6:0] addr_d, addr_q;
   logic flags_we_d, flags_we_q;
   logic carry_d, carry_q;
   logic zero_d, zero_q;

   // The shift itself is pure logic; only its outcome is registered here.
   lsu_shifter u_shifter (
      .op_i(op_i),
      .operand_i(operand_i),
      .result_o(shift_res),
      .carry_o(shift_c),
      .zero_o(shift_z)
   );

   // Result, address and flags keep their last value between instructions, so the core may
   // read them late; the strobes fall back to zero on every idle cycle.
   always_comb begin
      result_d = result_q;
      addr_d = addr_q;
      carry_d = carry_q;
      zero_d = zero_q;
      acc_we_d = 1'h0;
      file_we_d = 1'h0;
      flags_we_d = 1'h0;
      if (exec_i) begin
         result_d = shift_res;
         addr_d = addr_i;
         acc_we_d = (dest_i == DEST_W_SEL);
         file_we_d = (dest_i == DEST_F_SEL);
         flags_we_d = 1'h1;
         carry_d = shift_c;
         zero_d = shift_z;
      end
   end

   // Reset is synchronous and clears everything, so no write strobe can leave reset high.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         result_q <= DATA_RST;
         addr_q <= ADDR_RST;
         acc_we_q <= 1'h0;
         file_we_q <= 1'h0;
         flags_we_q <= 1'h0;
         carry_q <= 1'h0;
         zero_q <= 1'h0;
      end else begin
         result_q <= result_d;
         addr_q <= addr_d;
         acc_we_q <= acc_we_d;
         file_we_q <= file_we_d;
         flags_we_q <= flags_we_d;
         carry_q <= carry_d;
         zero_q <= zero_d;
      end
   end

   // Every output comes straight from a flip-flop, so the core sees no glitches.
   assign result_o = result_q;
   assign acc_we_o = acc_we_q;
   assign file_we_o = file_we_q;
   assign file_addr_o = addr_q;
   assign flags_we_o = flags_we_q;
   assign carry_o = carry_q;
   assign zero_o = zero_q;

   // The checks below compare outputs with the inputs taken one edge earlier, except a_zero_flag and a_one_dest, which compare outputs in the same cycle.
   property p_left_data;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_left_logical_op) |=>
         (result_o[7:1] == $past(operand_i[6:0]) && carry_o == $past(operand_i[7]));
   endproperty
   a_left_data: assert property (p_left_data) else $error("left shift data wrong");

   property p_left_fill;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_left_logical_op) |=> (result_o[0] == 1'b0);
   endproperty
   a_left_fill: assert property (p_left_fill) else $error("left shift lsb not zero");

   property p_right_data;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_right_logical_op) |=>
         (result_o[6:0] == $past(operand_i[7:1]) && carry_o == $past(operand_i[0]));
   endproperty
   a_right_data: assert property (p_right_data) else $error("right shift data wrong");

   property p_right_fill;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_right_logical_op) |=> (result_o[7] == 1'b0);
   endproperty
   a_right_fill: assert property (p_right_fill) else $error("right shift msb not zero");

   property p_dest_sel;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i |=> (acc_we_o == !$past(dest_i) && file_we_o == $past(dest_i)
         && file_addr_o == $past(addr_i));
   endproperty
   a_dest_sel: assert property (p_dest_sel) else $error("destination select wrong");

   property p_no_write_idle;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !exec_i |=> (!acc_we_o && !file_we_o && !flags_we_o);
   endproperty
   a_no_write_idle: assert property (p_no_write_idle) else $error("write without exec");

   property p_zero_flag;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      flags_we_o |-> (zero_o == (result_o == 8'h00));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_flags_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (!exec_i && !$past(exec_i)) |=> ($stable(carry_o) && $stable(result_o));
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("idle state changed");

   // A write strobe always comes with a flag update, and never both destinations at once.
   property p_flags_strobe;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i |=> flags_we_o;
   endproperty
   a_flags_strobe: assert property (p_flags_strobe) else $error("flag strobe missing");

   property p_one_dest;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      flags_we_o |-> (acc_we_o != file_we_o);
   endproperty
   a_one_dest: assert property (p_one_dest) else $error("two or no destinations");

   property p_exec_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i |=> (acc_we_o || file_we_o);
   endproperty
   a_exec_write: assert property (p_exec_write) else $error("result not written");

   // The zero flag is checked against the operand bits that survive the shift, so a
   // wrong fill bit or a stale result shows up here as well.
   property p_left_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_left_logical_op) |=>
         (zero_o == ($past(operand_i[6:0]) == 7'h00));
   endproperty
   a_left_zero: assert property (p_left_zero) else $error("left zero flag wrong");

   property p_right_zero;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec_i && op_i == shift_right_logical_op) |=>
         (zero_o == ($past(operand_i[7:1]) == 7'h00));
   endproperty
   a_right_zero: assert property (p_right_zero) else $error("right zero flag wrong");

   // Between instructions the core may read the flags at any time, so nothing may drift.
   property p_idle_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !exec_i |=> ($stable(result_o) && $stable(carry_o) && $stable(zero_o)
         && $stable(file_addr_o));
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("outputs moved while idle");

   // The reset checks are not disabled by reset, since they watch reset itself.
   property p_reset_quiet;
      @(posedge ref_clk_i)
      !rst_n_i |=> (!acc_we_o && !file_we_o && !flags_we_o);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("strobe after reset");

   property p_reset_clear;
      @(posedge ref_clk_i)
      !rst_n_i |=> (result_o == 8'h00 && carry_o == 1'h0 && zero_o == 1'h0
         && file_addr_o == 7'h00);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not reset");

   // Covers for the main scenarios: each direction, each destination and a change of
   // direction between two back-to-back instructions.
   c_left_to_acc: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i && op_i == shift_left_logical_op && !dest_i);
   c_right_to_file: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i && op_i == shift_right_logical_op && dest_i);
   c_zero_result: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      flags_we_o && zero_o && carry_o);
   c_right_to_acc: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i && op_i == shift_right_logical_op && !dest_i);
   c_back_to_back: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_i && $past(exec_i) && op_i != $past(op_i));
endmodule // lsu_logical_shift_unit
`default_nettype wire

// ---- lsu_pkg.sv ----
// Package of constants and types for the logical shift unit.
`default_nettype none
package lsu_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned MSB_POS = 7;
   localparam int unsigned LSB_POS = 0;
   localparam logic DEST_W_SEL = 1'h0;
   localparam logic DEST_F_SEL = 1'h1;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic FILL_BIT = 1'h0;
   typedef enum logic {
      shift_left_logical_op,
      shift_right_logical_op
   } lsu_op_type;
endpackage
`default_nettype wire

// ---- lsu_shifter.sv ----
// Combinational shifter that returns the shifted byte, carry out and zero result.
`timescale 1ns/10ps
`default_nettype none
module lsu_shifter
   import lsu_pkg::*;
(
   input wire lsu_pkg::lsu_op_type op_i,
   input wire logic [7:0] operand_i,
   output logic [7:0] result_o,
   output logic carry_o,
   output logic zero_o
);
   import lsu_pkg::*;

   always_comb begin
      if (op_i == shift_left_logical_op) begin
         result_o = {operand_i[6:0], FILL_BIT};
         carry_o = operand_i[MSB_POS];
      end else begin
         result_o = {FILL_BIT, operand_i[7:1]};
         carry_o = operand_i[LSB_POS];
      end
      zero_o = (result_o == DATA_RST);
   end
endmodule // lsu_shifter
`default_nettype wire
